// ===== rtl/local_bus_cycle_status.sv
/*
 * Local memory bus cycle sequencer: makes the two quarter-shifted local
 * clocks, runs row/column/data bus cycles with status bits, stretches
 * them by the ready input and synchronises the interrupt inputs.
 * Assumes a software port on clk, and pins asynchronous to clk.
 */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module local_bus_cycle_status
	import local_bus_pkg::*;
#(
	parameter int QUARTER_CLKS = QUARTER_TICKS
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [7:0]       address,
	input  wire logic [31:0]      write_data,
	input  wire logic             write_strobe,
	input  wire logic             read_strobe,
	output var  logic [31:0]      read_data,
	output var  logic             local_clock_a,
	output var  logic             local_clock_b,
	input  wire logic             local_ready_in,
	input  wire logic             ext_irq_a_n,
	input  wire logic             ext_irq_b_n,
	input  wire logic [BUS_W-1:0] mux_addr_data_bus_in,
	output var  logic [BUS_W-1:0] mux_addr_data_bus_out,
	output var  logic             mux_addr_data_bus_oe,
	output var  logic             row_strobe_n,
	output var  logic             col_strobe_n,
	output var  logic             write_strobe_n,
	output var  logic             shift_xfer_oe_pin
);

	// ------------------------------------------------------------
	// Types, checks and declarations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ROW  = 4'h2,
		ST_COL  = 4'h4,
		ST_DATA = 4'h8
	} seq_state_type;

	localparam int PRE_W = (QUARTER_CLKS > 1) ? $clog2(QUARTER_CLKS) : 1;

	if (QUARTER_CLKS < 1 || QUARTER_CLKS > 4096) begin : g_bad_div
		$error("local_bus_cycle_status: QUARTER_CLKS out of range");
	end

	seq_state_type     state_reg;
	bus_cmd_type       cmd_reg;
	bus_cmd_type       active_reg;
	logic              pending_reg;
	logic              done_reg;
	logic              irq_a_reg;
	logic              irq_b_reg;
	logic [BUS_W-1:0]  rdata_reg;
	logic [PRE_W-1:0]  pre_reg;
	logic [1:0]        phase_reg;
	logic [1:0]        phase_next;
	logic              quarter_tick;
	logic              period_tick;
	logic              finish;
	logic [SYNC_W-1:0] sync_q;
	logic              ready_s;
	logic              irq_a_s;
	logic              irq_b_s;
	logic [BUS_W-1:0]  bus_in_s;

	function automatic logic is_write(input cycle_kind_type k);
		return (k == KIND_WRITE) || (k == KIND_XFER_WR);
	endfunction

	function automatic logic is_read(input cycle_kind_type k);
		return (k == KIND_READ) || (k == KIND_FETCH);
	endfunction

	function automatic logic is_refresh(input cycle_kind_type k);
		return (k == KIND_REF_RAS) || (k == KIND_REF_CBR);
	endfunction

	function automatic logic is_xfer(input cycle_kind_type k);
		return (k == KIND_XFER_RD) || (k == KIND_XFER_WR);
	endfunction

	// ------------------------------------------------------------
	// Synchronisers for ready, interrupts and read data
	// ------------------------------------------------------------
	sync_chain #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk         (clk),
		.rstn        (rstn),
		.async_in    ({local_ready_in, ext_irq_a_n, ext_irq_b_n, mux_addr_data_bus_in}),
		.reset_level ({3'h7, 16'h0000}),
		.sync_out    (sync_q)
	);

	assign ready_s  = sync_q[SYNC_W-1];
	assign irq_a_s  = ~sync_q[SYNC_W-2];
	assign irq_b_s  = ~sync_q[SYNC_W-3];
	assign bus_in_s = sync_q[BUS_W-1:0];

	// ------------------------------------------------------------
	// Local clock generation
	// ------------------------------------------------------------
	assign quarter_tick = (pre_reg == PRE_W'(QUARTER_CLKS - 1));
	assign phase_next   = phase_reg + 2'h1;
	assign period_tick  = quarter_tick && (phase_reg == PHASE_LAST);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pre_reg <= '0;
		end else if (quarter_tick) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + PRE_W'(1);
		end
	end

	// Clock b leads clock a by one quarter period
	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_reg     <= PHASE_RESET;
			local_clock_a <= 1'b0;
			local_clock_b <= 1'b0;
		end else if (quarter_tick) begin
			phase_reg     <= phase_next;
			local_clock_a <= phase_next[1];
			local_clock_b <= phase_next[1] ^ phase_next[0];
		end
	end

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	// Internal cycles ignore ready; bus cycles hold in the data phase
	assign finish = period_tick && (state_reg == ST_DATA) &&
		(ready_s || active_reg.kind == KIND_INTERNAL);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg  <= ST_IDLE;
			active_reg <= '0;
		end else if (period_tick) begin
			case (state_reg)
				ST_IDLE: begin
					if (pending_reg) begin
						active_reg <= cmd_reg;
						state_reg  <= (cmd_reg.kind == KIND_INTERNAL) ? ST_DATA : ST_ROW;
					end
				end
				ST_ROW:  state_reg <= ST_COL;
				ST_COL:  state_reg <= ST_DATA;
				ST_DATA: begin
					if (finish) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Bus lines and strobes move only on local clock period edges
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mux_addr_data_bus_out <= '0;
			mux_addr_data_bus_oe  <= 1'b0;
			row_strobe_n          <= 1'b1;
			col_strobe_n          <= 1'b1;
			write_strobe_n        <= 1'b1;
			shift_xfer_oe_pin     <= 1'b1;
		end else if (period_tick) begin
			case (state_reg)
				ST_IDLE: begin
					if (pending_reg && cmd_reg.kind != KIND_INTERNAL) begin
						mux_addr_data_bus_out <= {~is_refresh(cmd_reg.kind), cmd_reg.row};
						mux_addr_data_bus_oe  <= 1'b1;
						shift_xfer_oe_pin     <= (cmd_reg.kind == KIND_FETCH);
						col_strobe_n          <= (cmd_reg.kind != KIND_REF_CBR);
					end
				end
				ST_ROW: begin
					row_strobe_n          <= 1'b0;
					mux_addr_data_bus_out <= {~is_xfer(active_reg.kind),
						(active_reg.kind == KIND_FETCH), active_reg.col};
				end
				ST_COL: begin
					col_strobe_n          <= 1'b0;
					write_strobe_n        <= ~is_write(active_reg.kind);
					mux_addr_data_bus_out <= active_reg.wdata;
					mux_addr_data_bus_oe  <= (active_reg.kind == KIND_WRITE);
					shift_xfer_oe_pin     <= ~is_read(active_reg.kind) &&
						~is_xfer(active_reg.kind);
				end
				ST_DATA: begin
					if (finish) begin
						mux_addr_data_bus_oe <= 1'b0;
						row_strobe_n         <= 1'b1;
						col_strobe_n         <= 1'b1;
						write_strobe_n       <= 1'b1;
						shift_xfer_oe_pin    <= 1'b1;
					end
				end
				default: mux_addr_data_bus_oe <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_reg <= '0;
		end else if (finish && is_read(active_reg.kind)) begin
			rdata_reg <= bus_in_s;
		end
	end

	// ------------------------------------------------------------
	// Software port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_reg <= '0;
		end else if (write_strobe) begin
			case (address)
				ROW_ADDR_OFS: cmd_reg.row   <= write_data[ROW_W-1:0];
				COL_ADDR_OFS: cmd_reg.col   <= write_data[COL_W-1:0];
				WR_DATA_OFS:  cmd_reg.wdata <= write_data[BUS_W-1:0];
				CMD_OFS: begin
					if (!pending_reg) begin
						cmd_reg.kind <= cycle_kind_type'(write_data[KIND_W-1:0]);
					end
				end
				default: cmd_reg <= cmd_reg;
			endcase
		end
	end

	// A command written while one is queued is dropped, not overwritten
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pending_reg <= 1'b0;
		end else if (write_strobe && address == CMD_OFS && !pending_reg) begin
			pending_reg <= 1'b1;
		end else if (period_tick && state_reg == ST_IDLE) begin
			pending_reg <= 1'b0;
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!rstn) begin
			done_reg  <= 1'b0;
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
		end else begin
			if (finish) begin
				done_reg <= 1'b1;
			end else if (write_strobe && address == STATUS_OFS && write_data[ST_DONE]) begin
				done_reg <= 1'b0;
			end
			if (irq_a_s) begin
				irq_a_reg <= 1'b1;
			end else if (write_strobe && address == STATUS_OFS && write_data[ST_IRQ_A]) begin
				irq_a_reg <= 1'b0;
			end
			if (irq_b_s) begin
				irq_b_reg <= 1'b1;
			end else if (write_strobe && address == STATUS_OFS && write_data[ST_IRQ_B]) begin
				irq_b_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			read_data <= WORD_RESET;
		end else if (read_strobe) begin
			case (address)
				ROW_ADDR_OFS: read_data <= 32'(cmd_reg.row);
				COL_ADDR_OFS: read_data <= 32'(cmd_reg.col);
				WR_DATA_OFS:  read_data <= 32'(cmd_reg.wdata);
				CMD_OFS:      read_data <= 32'(cmd_reg.kind);
				STATUS_OFS:   read_data <= 32'({irq_b_s, irq_a_s, irq_b_reg, irq_a_reg,
					ready_s, done_reg, (pending_reg || state_reg != ST_IDLE)});
				RD_DATA_OFS:  read_data <= 32'(rdata_reg);
				default:      read_data <= WORD_RESET;
			endcase
		end else begin
			read_data <= WORD_RESET;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/local_bus_pkg.sv
/*
 * Package for the local memory bus cycle sequencer: register offsets, field
 * positions, reset values, cycle kinds and the command carrier.
 * Assumes a 32-bit software port with byte addresses on word boundaries.
 */
package local_bus_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ROW_ADDR_OFS   = 8'h00;
	localparam logic [7:0] COL_ADDR_OFS   = 8'h04;
	localparam logic [7:0] WR_DATA_OFS    = 8'h08;
	localparam logic [7:0] CMD_OFS        = 8'h0C;
	localparam logic [7:0] STATUS_OFS     = 8'h10;
	localparam logic [7:0] RD_DATA_OFS    = 8'h14;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int BUS_W        = 16;
	localparam int ROW_W        = 15;
	localparam int COL_W        = 14;
	localparam int KIND_W       = 3;
	localparam int REFRESH_BIT  = 15;
	localparam int XFER_BIT     = 15;
	localparam int FETCH_BIT    = 14;
	localparam int ST_BUSY      = 0;
	localparam int ST_DONE      = 1;
	localparam int ST_READY     = 2;
	localparam int ST_IRQ_A     = 3;
	localparam int ST_IRQ_B     = 4;
	localparam int ST_IRQ_A_LVL = 5;
	localparam int ST_IRQ_B_LVL = 6;
	localparam int SYNC_W       = BUS_W + 3;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam logic [1:0]  PHASE_RESET   = 2'h0;
	localparam logic [1:0]  PHASE_LAST    = 2'h3;
	localparam int          QUARTER_TICKS = 1;

	// ------------------------------------------------------------
	// Cycle kinds
	// ------------------------------------------------------------
	typedef enum logic [KIND_W-1:0] {
		KIND_INTERNAL = 3'h0,
		KIND_READ     = 3'h1,
		KIND_WRITE    = 3'h2,
		KIND_FETCH    = 3'h3,
		KIND_XFER_RD  = 3'h4,
		KIND_XFER_WR  = 3'h5,
		KIND_REF_RAS  = 3'h6,
		KIND_REF_CBR  = 3'h7
	} cycle_kind_type;

	typedef struct packed {
		cycle_kind_type    kind;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [BUS_W-1:0]  wdata;
	} bus_cmd_type;

endpackage

// ===== rtl/sync_chain.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bus coherence is given across bits.
 */
`timescale 1ns/1ps
`default_nettype none

module sync_chain #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_level,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] hold_reg;

	if (WIDTH < 1) begin : g_bad_width
		$error("sync_chain: WIDTH must be at least 1");
	end

	// First stage feeds only the second stage; both hold the offset from
	// the idle level, so reset reads as idle and no false request follows
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_reg <= '0;
			hold_reg <= '0;
		end else begin
			meta_reg <= async_in ^ reset_level;
			hold_reg <= meta_reg;
		end
	end

	assign sync_out = hold_reg ^ reset_level;

endmodule

`default_nettype wire

// ===== verification/local_bus_cycle_status_chk.sv
/*
 * Pin checker for the local bus cycle sequencer.
 * Assumes QUARTER_CLKS of 1, so a local period is four clk cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module local_bus_cycle_status_chk
	import local_bus_pkg::*;
#(
	parameter int QUARTER_CLKS = 1
) (
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic		read_strobe,
	input wire logic [31:0]		read_data,
	input wire logic		local_clock_a,
	input wire logic		local_clock_b,
	input wire logic		local_ready_in,
	input wire logic [BUS_W-1:0]	mux_addr_data_bus_out,
	input wire logic		mux_addr_data_bus_oe,
	input wire logic		row_strobe_n,
	input wire logic		col_strobe_n,
	input wire logic		write_strobe_n,
	input wire logic		shift_xfer_oe_pin
);
	if (QUARTER_CLKS != 1) begin : g_bad_quarter
		$error("local_bus_cycle_status_chk: QUARTER_CLKS must be 1");
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_clock_shape: assert property (
		$rose(local_clock_a) |-> local_clock_a[*2] ##1 !local_clock_a)
		else $error("clock a shape wrong");
	chk_clock_quarter: assert property (
		$rose(local_clock_b) |=> $rose(local_clock_a))
		else $error("clock b not a quarter ahead");
	chk_pins_on_tick: assert property (
		!$stable({row_strobe_n, col_strobe_n, write_strobe_n, shift_xfer_oe_pin,
		mux_addr_data_bus_out, mux_addr_data_bus_oe}) |-> $fell(local_clock_a))
		else $error("bus pins moved off tick");
	chk_col_after_row: assert property (
		$fell(row_strobe_n) |-> ##4 !col_strobe_n)
		else $error("column strobe late");
	chk_fetch_line: assert property (
		$fell(row_strobe_n) |-> mux_addr_data_bus_out[FETCH_BIT] == shift_xfer_oe_pin)
		else $error("line 14 differs from transfer pin");
	chk_refresh_cbr: assert property (
		$fell(row_strobe_n) && !$past(col_strobe_n)
		|-> !$past(mux_addr_data_bus_out[REFRESH_BIT]))
		else $error("refresh bit high in refresh");
	chk_ready_end: assert property (
		$rose(row_strobe_n) |-> $past(local_ready_in, 3))
		else $error("cycle ended with ready low");
	chk_write_pulse: assert property (
		$fell(write_strobe_n) && shift_xfer_oe_pin |-> !col_strobe_n)
		else $error("write strobe outside column strobe");
	chk_rdata_idle: assert property (
		!$past(read_strobe) |-> read_data == 32'h0000_0000)
		else $error("read data outside its cycle");

	cover property ($fell(row_strobe_n));
	cover property ($fell(write_strobe_n) && shift_xfer_oe_pin);
	cover property ($rose(row_strobe_n) && !$past(local_ready_in, 7));
endmodule

bind local_bus_cycle_status local_bus_cycle_status_chk #(.QUARTER_CLKS(QUARTER_CLKS)) chk_inst (
	.clk(clk), .rstn(rstn), .read_strobe(read_strobe), .read_data(read_data),
	.local_clock_a(local_clock_a), .local_clock_b(local_clock_b),
	.local_ready_in(local_ready_in), .mux_addr_data_bus_out(mux_addr_data_bus_out),
	.mux_addr_data_bus_oe(mux_addr_data_bus_oe), .row_strobe_n(row_strobe_n),
	.col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
	.shift_xfer_oe_pin(shift_xfer_oe_pin)
);

`default_nettype wire

// ===== verification/bus_partner.sv
/*
 * Far-side memory and ready source for the local bus pins.
 * Assumes eight column bits decode; ready stalls start at row strobe fall.
 */
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
	input wire logic		clk,
	input wire logic [7:0]		stall,
	input wire logic		hold,
	input wire logic		ras_n,
	input wire logic		cas_n,
	input wire logic		we_n,
	input wire logic		xoe,
	input wire logic		oe,
	input wire logic [15:0]		bus_out,
	output var logic [15:0]		bus_in,
	output var logic		rdy
);
	logic [15:0]	mem [256];
	logic [7:0]	col_q;
	logic [7:0]	cnt;
	logic		ras_q;

	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		bus_in = 16'h0000;
		cnt = 8'h00;
		ras_q = 1'b1;
		col_q = 8'h00;
	end

	// Counted stalls are short, but hold keeps ready low for as long as it is set
	assign rdy = !hold && cnt == 8'h00;

	always @(posedge clk) begin
		ras_q <= ras_n;
		if (ras_q && !ras_n)
			cnt <= stall;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		if (!ras_n && cas_n)
			col_q <= bus_out[7:0];
		if (!we_n && !cas_n && oe)
			mem[col_q] <= bus_out;
		// Undriven bus flips so a stale value never looks valid
		bus_in <= (!xoe && !cas_n && !oe) ? mem[col_q] : ~bus_in;
	end
endmodule

`default_nettype wire

// ===== verification/tb_local_bus_cycle_status.sv
/*
 * Bench for the local bus cycle sequencer: register tasks and bus word monitor.
 * Assumes the partner model answers on the memory side.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_local_bus_cycle_status
	import local_bus_pkg::*;
;
	logic		clk, rstn, write_strobe, read_strobe, hold, irq_a_n, irq_b_n;
	logic		lca, lcb, rdy, oe, ras_n, cas_n, we_n, xoe, prev_ras;
	logic [7:0]	address, stall;
	logic [15:0]	bus_in, bus_out, prev_bus, row_w, col_w;
	logic [31:0]	write_data, read_data, n_fail, checked, cyc, t0, len, ras_cnt;

	local_bus_cycle_status #(.QUARTER_CLKS(1)) local_bus_cycle_status_inst (
		.clk(clk), .rstn(rstn), .address(address), .write_data(write_data),
		.write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
		.local_clock_a(lca), .local_clock_b(lcb), .local_ready_in(rdy),
		.ext_irq_a_n(irq_a_n), .ext_irq_b_n(irq_b_n), .mux_addr_data_bus_in(bus_in),
		.mux_addr_data_bus_out(bus_out), .mux_addr_data_bus_oe(oe), .row_strobe_n(ras_n),
		.col_strobe_n(cas_n), .write_strobe_n(we_n), .shift_xfer_oe_pin(xoe));

	bus_partner bus_partner_inst (.clk(clk), .stall(stall), .hold(hold), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .xoe(xoe), .oe(oe), .bus_out(bus_out),
		.bus_in(bus_in), .rdy(rdy));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		@(negedge clk);
		q = read_data;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		chk(q, e);
	endtask

	// Bounded poll: a lost done bit must not hang the run
	task automatic run(input int k, input logic [14:0] r, input logic [15:0] d);
		logic [31:0] s;
		int n;
		wr(ROW_ADDR_OFS, {17'h0, r});
		wr(COL_ADDR_OFS, 32'h0000_0012);
		wr(WR_DATA_OFS, {16'h0, d});
		wr(CMD_OFS, 32'(k));
		n = 0;
		do begin
			rd(STATUS_OFS, s);
			if (n == 0) chk({31'h0, s[ST_BUSY]}, 32'h0000_0001);
			n++;
		end while (s[ST_DONE] !== 1'b1 && n < 50);
		chk({31'h0, s[ST_DONE]}, 32'h0000_0001);
		wr(STATUS_OFS, 32'h0000_0002);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Row word is the bus just before row strobe falls, column word just after
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prev_bus <= bus_out;
		prev_ras <= ras_n;
		if (prev_ras && !ras_n) begin
			row_w <= prev_bus;
			col_w <= bus_out;
			t0 <= cyc;
			ras_cnt <= ras_cnt + 1;
		end
		if (!prev_ras && ras_n)
			len <= cyc - t0;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		test_done;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [31:0] rc;
		{rstn, write_strobe, read_strobe, hold, address, stall, write_data} = '0;
		{irq_a_n, irq_b_n, prev_ras} = 3'h7;
		{n_fail, checked, cyc, t0, len, ras_cnt} = '0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({28'h0, ras_n, cas_n, we_n, xoe}, 32'h0000_000F);
		rdc(8'h18, 32'h0000_0000);
		wr(ROW_ADDR_OFS, 32'hFFFF_FFFF);
		rdc(ROW_ADDR_OFS, 32'h0000_7FFF);
		wr(COL_ADDR_OFS, 32'hFFFF_FFFF);
		rdc(COL_ADDR_OFS, 32'h0000_3FFF);
		for (int k = 1; k < 8; k++) begin
			stall <= k[0] ? 8'h06 : 8'h00;
			run(k, 15'h2AAA ^ 15'(k), 16'hA5C3 ^ 16'(k));
			chk({16'h0, row_w}, {16'h0, k < 6, 15'h2AAA ^ 15'(k)});
			chk({16'h0, col_w}, {16'h0, !(k == 4 || k == 5), k == 3, 14'h0012});
			chk(len, k[0] ? 32'h0000_000C : 32'h0000_0008);
			if (k == 3) rdc(RD_DATA_OFS, 32'h0000_A5C1);
		end
		hold <= 1'b1;
		rc = ras_cnt;
		run(0, 15'h0000, 16'h0000);
		chk(ras_cnt, rc);
		rdc(STATUS_OFS, 32'h0000_0000);
		@(posedge clk);
		hold <= 1'b0;
		irq_a_n <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(STATUS_OFS, 32'h0000_002C);
		wr(STATUS_OFS, 32'h0000_0008);
		irq_b_n <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(STATUS_OFS, 32'h0000_007C);
		@(posedge clk);
		irq_a_n <= 1'b1;
		irq_b_n <= 1'b1;
		repeat (4) @(posedge clk);
		wr(STATUS_OFS, 32'h0000_0018);
		rdc(STATUS_OFS, 32'h0000_0004);
		test_done;
	end
endmodule

`default_nettype wire
